// *** inc/slf_pkg.sv ***
// slf_pkg: register map, field positions, modes and helper decoders
// for the segment lcd frame timing block.
// assumes: a byte-addressed avalon-mm slave, one 32-bit word per register.
package slf_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL    = 6'h00; // lcd_control_reg
  localparam logic [5:0] IDX_PHASE   = 6'h01; // lcd_phase_reg
  localparam logic [5:0] IDX_SEGEN0  = 6'h02; // segment_enable_regs 0..5
  localparam logic [5:0] IDX_SEGEND  = 6'h08;
  localparam logic [5:0] IDX_PIX0    = 6'h08; // pixel_data_regs 0..23
  localparam logic [5:0] IDX_PIXEND  = 6'h20;
  localparam int         N_SEGEN     = 6;
  localparam int         N_PIX       = 24;
  localparam int         N_SEG       = 48;
  localparam int         N_COM       = 4;
  localparam int         N_SHARED    = 3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN     = 7;
  localparam int CTRL_LCD_SLEEP_ENABLE  = 6;
  localparam int CTRL_PIXEL_WRITE_ERROR_FLAG   = 5;
  localparam int CTRL_SRC_LO = 2;
  localparam int CTRL_MUX_LO = 0;
  localparam int PH_WFT      = 7;
  localparam int PH_BIAS     = 6;
  localparam int PH_ACT      = 5;
  localparam int PH_WA       = 4;
  localparam int PH_PS_LO    = 0;

  // ----------------------------------------------------------------
  // encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_SYS     = 2'h0; // instruction clock / 8192
  localparam logic [1:0] SRC_SEC     = 2'h1; // secondary osc / 32
  localparam logic [1:0] MUX_STATIC  = 2'h0;
  localparam logic [1:0] MUX_HALF    = 2'h1;
  localparam logic [1:0] MUX_THIRD   = 2'h2;
  localparam int         SYS_DIV_DEF = 8192;
  localparam logic [4:0] OSC_DIV_M1  = 5'h1F; // divide by 32
  localparam int         PRESC_W     = 16;
  localparam logic [7:0] RST_BYTE    = 8'h00;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_RUN   = 3'b010,
    ST_SLEEP = 3'b100
  } slf_state_t;

  // last prescaler step of a frame: 4x1, 2x2, 1x3, 1x4 steps
  function automatic logic [1:0] slf_last_step(input logic [1:0] mux);
    slf_last_step = (mux == MUX_THIRD) ? 2'h2 : 2'h3;
  endfunction : slf_last_step

  // common slice active in a given step
  function automatic logic [1:0] slf_com_idx(input logic [1:0] mux,
                                             input logic [1:0] step);
    case (mux)
      MUX_STATIC: slf_com_idx = 2'h0;
      MUX_HALF:   slf_com_idx = {1'b0, step[1]};
      default:    slf_com_idx = step;
    endcase
  endfunction : slf_com_idx

  // shared port pins 4..6 taken over as common drivers
  function automatic logic [2:0] slf_mux_pins(input logic [1:0] mux);
    case (mux)
      MUX_STATIC: slf_mux_pins = 3'h0;
      MUX_HALF:   slf_mux_pins = 3'h1;
      MUX_THIRD:  slf_mux_pins = 3'h3;
      default:    slf_mux_pins = 3'h7;
    endcase
  endfunction : slf_mux_pins

endpackage : slf_pkg

// *** verif/slf_frame_timing_test.sv ***
// slf_frame_timing_test: self-checking bench for the frame timing block.
// assumes: system divider shortened to 16, one register byte per word.
`timescale 1ns/10ps
`default_nettype none

module slf_frame_timing_test;
  localparam int SDIV = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        rc = 1'b0;
  logic        slp = 1'b0;
  logic [2:0]  sh_dir = 3'h7;
  logic [47:0] sg_dir = {48{1'b1}};
  logic        wreq, phase, fstart, irq, active, overlap, p;
  logic [31:0] rdat;
  logic [3:0]  com, seen;
  logic [47:0] seg, sg_lcd, sg_oe;
  logic [2:0]  sh_com, sh_oe;
  logic [7:0]  q;
  int          fail_count = 0;
  int          total_checks = 0;
  int          rcc = 0;
  int          cyc, nirq, k2;
  // register rows: address, write byte, expected read byte
  logic [23:0] rows [5] = '{24'h08A5A5, 24'h203C3C, 24'h7CFFFF,
                            24'h80FF00, 24'h000D0D};
  logic [2:0]  pins [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [3:0]  cm [4] = '{4'h1, 4'h3, 4'h7, 4'hF};
  logic [7:0]  pss [4] = '{8'h02, 8'h00, 8'h01, 8'h01};
  int          st [4] = '{4, 4, 3, 4};

  always #5 clk = ~clk;
  // slow oscillator stand-in, period four system cycles
  always @(posedge clk) begin
    rcc <= rcc + 1;
    rc  <= rcc[1];
  end

  slf_frame_timing #(.SYS_DIV(SDIV)) dut_u (
    .i_sys_clk(clk), .i_resetn(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_waitrequest(wreq), .o_avs_readdata(rdat),
    .i_secondary_osc_clk_in(rc), .i_internal_rc_osc(rc),
    .i_cpu_sleep(slp), .i_shared_pin_direction_bit(sh_dir),
    .i_seg_pin_direction_bit(sg_dir), .o_common_line(com),
    .o_seg_drive(seg), .o_drive_phase(phase), .o_frame_start(fstart),
    .o_frame_irq(irq), .o_lcd_active(active),
    .o_shared_pin_is_common(sh_com), .o_shared_pin_oe(sh_oe),
    .o_seg_pin_is_lcd(sg_lcd), .o_seg_pin_oe(sg_oe));

  slf_glass_panel panel_u (.i_clk(clk), .i_frame_start(fstart),
    .i_com(com), .o_com_seen(seen), .o_overlap(overlap));

  task check(input string nm, input logic [47:0] sv, input logic [47:0] ev);
    total_checks++;
    if (sv !== ev) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ev, sv);
    end
  endtask : check

  // one avalon transfer; request held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    check("bus_answer", n < 50, 1'b1);
  endtask : bus

  // measures the next whole frame in cycles and counts its interrupts
  task frame;
    int k;
    k = 0;
    while (fstart !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    cyc = 0;
    nirq = 0;
    do begin
      @(posedge clk);
      cyc++;
      if (irq === 1'b1) nirq++;
    end while (fstart !== 1'b1 && cyc < 4000);
    check("frame_limit", (k < 4000) && (cyc < 4000), 1'b1);
  endtask : frame

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #600000;
    fail_count++;
    $display("CHECK FAILED watchdog expected 0 seen 1");
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h00, 8'h00);
    check("ctrl_reset", q, 8'h00);
    check("shared_reset", sh_com, 3'h0);
    check("seg_reset", sg_lcd, 48'h0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, rows[i][23:16], rows[i][15:8]);
      bus(1'b0, rows[i][23:16], 8'h00);
      check("reg_row", q, rows[i][7:0]);
    end
    repeat (2) @(posedge clk);
    check("seg_is_lcd", sg_lcd[7:0], 8'hA5);
    check("seg_oe", sg_oe, {40'h0, 8'hA5});
    $display("test registers done");
    sh_dir <= 3'h2;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h00, m[7:0]);
      repeat (2) @(posedge clk);
      check("shared_common", sh_com, pins[m]);
      check("shared_oe", sh_oe, pins[m] | 3'h5);
    end
    $display("test pin takeover done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h04, pss[m]);
      bus(1'b1, 8'h00, 8'h80 | m[7:0]);
      frame();
      frame();
      check("frame_cycles", cyc, SDIV * (pss[m] + 1) * st[m]);
      check("irq_type_a", nirq, 0);
      check("com_seen", seen, cm[m]);
      check("com_overlap", overlap, 1'b0);
      check("seg_drive", seg, 48'h24);
    end
    $display("test frame rate done");
    bus(1'b1, 8'h04, 8'h81);
    bus(1'b1, 8'h00, 8'h83);
    frame();
    frame();
    p = phase;
    k2 = nirq;
    frame();
    check("phase_flip", phase ^ p, 1'b1);
    check("irq_pair", k2 + nirq, 1);
    bus(1'b1, 8'h00, 8'hA3);
    bus(1'b1, 8'h20, 8'h11);
    bus(1'b0, 8'h00, 8'h00);
    check("pixel_write_error_flag_set", q, 8'hA3);
    bus(1'b1, 8'h00, 8'h83);
    bus(1'b0, 8'h00, 8'h00);
    check("pixel_write_error_flag_clear", q, 8'h83);
    bus(1'b0, 8'h20, 8'h00);
    check("pixel_kept", q, 8'h3C);
    cyc = 0;
    while (irq !== 1'b1 && cyc < 4000) begin
      @(posedge clk);
      cyc++;
    end
    check("irq_seen", cyc < 4000, 1'b1);
    bus(1'b1, 8'h20, 8'h5A);
    bus(1'b0, 8'h00, 8'h00);
    check("pixel_write_error_flag_window", q, 8'h83);
    bus(1'b0, 8'h20, 8'h00);
    check("pixel_window", q, 8'h5A);
    bus(1'b1, 8'h00, 8'h80);
    frame();
    frame();
    check("irq_static_b", nirq, 0);
    $display("test write window done");
    bus(1'b1, 8'h04, 8'h01);
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, 8'h00, 8'h83 | (s[7:0] << 2));
      frame();
      frame();
      check("osc_frame", cyc, 1024);
    end
    slp <= 1'b1;
    repeat (20) @(posedge clk);
    check("osc_sleep_run", active, 1'b1);
    bus(1'b1, 8'h00, 8'hCF);
    repeat (4) @(posedge clk);
    check("lcd_sleep_enable_sleep", active, 1'b0);
    bus(1'b1, 8'h00, 8'h8F);
    repeat (4) @(posedge clk);
    check("osc_wake", active, 1'b1);
    bus(1'b1, 8'h00, 8'h83);
    repeat (4) @(posedge clk);
    check("sys_sleep", active, 1'b0);
    check("sys_sleep_com", com, 4'h0);
    slp <= 1'b0;
    $display("test clock sources done");
    final_report();
  end
endmodule : slf_frame_timing_test

`default_nettype wire

// *** verif/slf_glass_panel.sv ***
// slf_glass_panel: passive multiplexed glass model on the drive pins.
// assumes: fed by the frame timing block outputs on the system clock.
`timescale 1ns/10ps
`default_nettype none

module slf_glass_panel (
  input  wire logic       i_clk,
  input  wire logic       i_frame_start,
  input  wire logic [3:0] i_com,
  output logic      [3:0] o_com_seen,
  output logic            o_overlap
);
  // ----------------------------------------------------------------
  // common slice tracking
  // ----------------------------------------------------------------
  // a frame start restarts the tally; two slices at once would short
  // rows on real glass, so the overlap flag stays up for that frame
  always_ff @(posedge i_clk) begin
    if (i_frame_start) begin
      o_com_seen <= 4'h0;
      o_overlap  <= 1'b0;
    end else begin
      o_com_seen <= o_com_seen | i_com;
      o_overlap  <= o_overlap | ($countones(i_com) > 1);
    end
  end
endmodule : slf_glass_panel

`default_nettype wire

// *** verilog/slf_frame_timing.sv ***
// slf_frame_timing: frame clock, multiplex sequencing, pin takeover,
// pixel store and write window of a multiplexed segment lcd driver.
// assumes: all inputs synchronous to i_sys_clk, pin direction bits
// come from the port logic (1 = input), pads resolved outside.
`timescale 1ns/10ps
`default_nettype none

module slf_frame_timing #(
  parameter int SYS_DIV = slf_pkg::SYS_DIV_DEF
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic             o_avs_waitrequest,
  output logic [31:0]      o_avs_readdata,
  input  wire logic        i_secondary_osc_clk_in,
  input  wire logic        i_internal_rc_osc,
  input  wire logic        i_cpu_sleep,
  input  wire logic [2:0]  i_shared_pin_direction_bit,
  input  wire logic [47:0] i_seg_pin_direction_bit,
  output logic [3:0]       o_common_line,
  output logic [47:0]      o_seg_drive,
  output logic             o_drive_phase,
  output logic             o_frame_start,
  output logic             o_frame_irq,
  output logic             o_lcd_active,
  output logic [2:0]       o_shared_pin_is_common,
  output logic [2:0]       o_shared_pin_oe,
  output logic [47:0]      o_seg_pin_is_lcd,
  output logic [47:0]      o_seg_pin_oe
);

  localparam int SDW = $clog2(SYS_DIV);
  localparam logic [SDW-1:0] SYS_DIV_M1 = SDW'(SYS_DIV - 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]           segen_q [slf_pkg::N_SEGEN];
  logic [7:0]           segen_d [slf_pkg::N_SEGEN];
  logic [7:0]           pix_q   [slf_pkg::N_PIX];
  logic [7:0]           pix_d   [slf_pkg::N_PIX];
  logic                 wait_q, wait_d;
  logic [31:0]          rdata_q, rdata_d;
  logic                 en_q, en_d, lcd_sleep_enable_q, lcd_sleep_enable_d, pixel_write_error_flag_q, pixel_write_error_flag_d;
  logic                 wft_q, wft_d, bias_q, bias_d;
  logic [1:0]           src_q, src_d, mux_q, mux_d;
  logic [3:0]           ps_q, ps_d;
  slf_pkg::slf_state_t  state_q, state_d;
  logic [SDW-1:0]       sysdiv_q, sysdiv_d;
  logic [4:0]           secdiv_q, secdiv_d, rcdiv_q, rcdiv_d;
  logic                 sec_prev_q, rc_prev_q;
  logic [slf_pkg::PRESC_W-1:0] presc_q, presc_d;
  logic [1:0]           step_q, step_d;
  logic                 par_q, par_d, odd_q, odd_d, wa_q, wa_d;
  logic                 irq_d, fstart_d;
  logic                 req, commit, allowed, run, sleep_now;
  logic                 sys_tick, sec_tick, rc_tick, src_tick, p_tick;
  logic                 wrap, fetch_done, pair_mode, wa_set;
  logic [5:0]           idx;
  logic [4:0]           pidx;
  logic [2:0]           sidx;
  logic [7:0]           wbyte;
  logic [1:0]           com_nx;
  wire  logic [47:0]    seg_pix;
  wire  logic [47:0]    seg_en;

  assign req    = i_avs_read | i_avs_write;
  assign commit = req & ~wait_q;
  assign idx    = i_avs_address[7:2];
  assign pidx   = 5'(idx - slf_pkg::IDX_PIX0);
  assign sidx   = 3'(idx - slf_pkg::IDX_SEGEN0);
  assign wbyte  = i_avs_writedata[7:0];
  assign run    = (state_q == slf_pkg::ST_RUN);
  // a disabled module has no frame to tear, so writes always land
  assign allowed = ~run | wa_q;
  // the bus outputs are the answer flops themselves
  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata    = rdata_q;

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer for one cycle
  // ----------------------------------------------------------------
  always_comb begin
    wait_d  = ~(req & wait_q);
    rdata_d = rdata_q;
    if (req && wait_q) begin
      rdata_d = 32'h0000_0000; // unmapped reads return zero
      if (idx == slf_pkg::IDX_CTRL) begin
        rdata_d[7:0] = {en_q, lcd_sleep_enable_q, pixel_write_error_flag_q, 1'b0, src_q, mux_q};
      end else if (idx == slf_pkg::IDX_PHASE) begin
        rdata_d[7:0] = {wft_q, bias_q, run, allowed, ps_q};
      end else if (idx < slf_pkg::IDX_SEGEND) begin
        rdata_d[7:0] = segen_q[sidx];
      end else if (idx < slf_pkg::IDX_PIXEND) begin
        rdata_d[7:0] = pix_q[pidx];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // software registers; writes land at the edge waitrequest is low
  // ----------------------------------------------------------------
  always_comb begin
    en_d    = en_q;
    lcd_sleep_enable_d = lcd_sleep_enable_q;
    src_d   = src_q;
    mux_d   = mux_q;
    wft_d   = wft_q;
    bias_d  = bias_q;
    ps_d    = ps_q;
    pixel_write_error_flag_d  = pixel_write_error_flag_q;
    segen_d = segen_q;
    pix_d   = pix_q;
    if (commit && i_avs_write) begin
      if (idx == slf_pkg::IDX_CTRL) begin
        en_d    = wbyte[slf_pkg::CTRL_EN];
        lcd_sleep_enable_d = wbyte[slf_pkg::CTRL_LCD_SLEEP_ENABLE];
        src_d   = wbyte[slf_pkg::CTRL_SRC_LO +: 2];
        mux_d   = wbyte[slf_pkg::CTRL_MUX_LO +: 2];
        // writing zero clears the error, writing one leaves it
        pixel_write_error_flag_d  = pixel_write_error_flag_q & wbyte[slf_pkg::CTRL_PIXEL_WRITE_ERROR_FLAG];
      end else if (idx == slf_pkg::IDX_PHASE) begin
        wft_d  = wbyte[slf_pkg::PH_WFT];
        bias_d = wbyte[slf_pkg::PH_BIAS];
        ps_d   = wbyte[slf_pkg::PH_PS_LO +: 4];
      end else if (idx >= slf_pkg::IDX_SEGEN0 &&
                   idx < slf_pkg::IDX_SEGEND) begin
        segen_d[sidx] = wbyte;
      end else if (idx >= slf_pkg::IDX_PIX0 &&
                   idx < slf_pkg::IDX_PIXEND) begin
        if (allowed) begin
          pix_d[pidx] = wbyte;
        end else begin
          pixel_write_error_flag_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      en_q    <= 1'b0;
      lcd_sleep_enable_q <= 1'b0;
      pixel_write_error_flag_q  <= 1'b0;
      src_q   <= slf_pkg::SRC_SYS;
      mux_q   <= slf_pkg::MUX_STATIC;
      wft_q   <= 1'b0;
      bias_q  <= 1'b0;
      ps_q    <= 4'h0;
      for (int i = 0; i < slf_pkg::N_SEGEN; i++) begin
        segen_q[i] <= slf_pkg::RST_BYTE;
      end
      for (int i = 0; i < slf_pkg::N_PIX; i++) begin
        pix_q[i] <= slf_pkg::RST_BYTE;
      end
    end else begin
      en_q    <= en_d;
      lcd_sleep_enable_q <= lcd_sleep_enable_d;
      pixel_write_error_flag_q  <= pixel_write_error_flag_d;
      src_q   <= src_d;
      mux_q   <= mux_d;
      wft_q   <= wft_d;
      bias_q  <= bias_d;
      ps_q    <= ps_d;
      segen_q <= segen_d;
      pix_q   <= pix_d;
    end
  end

  // ----------------------------------------------------------------
  // frame clock sources, prescaler and slice sequencer
  // ----------------------------------------------------------------
  // the system divider stalls while the core sleeps, as its clock does
  assign sys_tick  = ~i_cpu_sleep & (sysdiv_q == SYS_DIV_M1);
  assign sec_tick  = i_secondary_osc_clk_in & ~sec_prev_q &
                     (secdiv_q == slf_pkg::OSC_DIV_M1);
  assign rc_tick   = i_internal_rc_osc & ~rc_prev_q &
                     (rcdiv_q == slf_pkg::OSC_DIV_M1);
  assign src_tick  = (src_q == slf_pkg::SRC_SYS) ? sys_tick :
                     (src_q == slf_pkg::SRC_SEC) ? sec_tick :
                     rc_tick;
  assign sleep_now = i_cpu_sleep &
                     ((src_q == slf_pkg::SRC_SYS) | lcd_sleep_enable_q);
  // at or above the limit: lowering the prescale mid-count must not
  // leave the counter to run round all 16 bits before the next step
  assign p_tick    = run & src_tick &
                     (presc_q >= {12'h000, ps_q});
  // a mux change mid-frame may leave the step past the new last one
  assign wrap      = p_tick & (step_q >= slf_pkg::slf_last_step(mux_q));
  assign fetch_done = p_tick &
                     (step_q == 2'(slf_pkg::slf_last_step(mux_q) - 2'h1));
  assign pair_mode = wft_q & (mux_q != slf_pkg::MUX_STATIC);
  // pair mode opens the window only in the last step of the second frame of a pair
  assign wa_set    = fetch_done & (~pair_mode | odd_q);
  assign irq_d     = wa_set & pair_mode;

  always_comb begin
    state_d  = state_q;
    // wrap at the divide value so a non power-of-two divider stays exact
    sysdiv_d = sysdiv_q;
    if (!i_cpu_sleep) begin
      sysdiv_d = (sysdiv_q == SYS_DIV_M1) ? '0 : SDW'(sysdiv_q + 1'b1);
    end
    secdiv_d = secdiv_q;
    rcdiv_d  = rcdiv_q;
    presc_d  = presc_q;
    step_d   = step_q;
    par_d    = par_q;
    odd_d    = odd_q;
    wa_d     = wa_q;
    fstart_d = 1'b0;
    if (i_secondary_osc_clk_in && !sec_prev_q) begin
      secdiv_d = 5'(secdiv_q + 1'b1);
    end
    if (i_internal_rc_osc && !rc_prev_q) begin
      rcdiv_d = 5'(rcdiv_q + 1'b1);
    end
    case (state_q)
      slf_pkg::ST_OFF: begin
        presc_d = '0;
        step_d  = 2'h0;
        par_d   = 1'b0;
        odd_d   = 1'b0;
        wa_d    = 1'b0;
        if (en_q) begin
          state_d  = slf_pkg::ST_RUN;
          fstart_d = 1'b1;
        end
      end
      slf_pkg::ST_RUN: begin
        if (!en_q) begin
          state_d = slf_pkg::ST_OFF;
        end else if (sleep_now) begin
          state_d = slf_pkg::ST_SLEEP;
        end
        if (p_tick) begin
          presc_d = '0;
          step_d  = 2'(step_q + 2'h1);
          par_d   = ~par_q;
        end else if (src_tick) begin
          presc_d = presc_q + 1'b1;
        end
        if (wa_set) begin
          wa_d = 1'b1;
        end
        if (wrap) begin
          step_d   = 2'h0;
          par_d    = 1'b0;
          odd_d    = ~odd_q;
          wa_d     = 1'b0;
          fstart_d = 1'b1;
        end
      end
      slf_pkg::ST_SLEEP: begin
        if (!en_q) begin
          state_d = slf_pkg::ST_OFF;
        end else if (!sleep_now) begin
          state_d = slf_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = slf_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_q    <= slf_pkg::ST_OFF;
      sysdiv_q   <= '0;
      secdiv_q   <= 5'h00;
      rcdiv_q    <= 5'h00;
      sec_prev_q <= 1'b0;
      rc_prev_q  <= 1'b0;
      presc_q    <= '0;
      step_q     <= 2'h0;
      par_q      <= 1'b0;
      odd_q      <= 1'b0;
      wa_q       <= 1'b0;
    end else begin
      state_q    <= state_d;
      sysdiv_q   <= sysdiv_d;
      secdiv_q   <= secdiv_d;
      rcdiv_q    <= rcdiv_d;
      sec_prev_q <= i_secondary_osc_clk_in;
      rc_prev_q  <= i_internal_rc_osc;
      presc_q    <= presc_d;
      step_q     <= step_d;
      par_q      <= par_d;
      odd_q      <= odd_d;
      wa_q       <= wa_d;
    end
  end

  // ----------------------------------------------------------------
  // pixel and enable maps per segment
  // ----------------------------------------------------------------
  assign com_nx = slf_pkg::slf_com_idx(mux_q, step_d);

  for (genvar s = 0; s < slf_pkg::N_SEG; s++) begin : g_seg
    localparam int BY = s / 8;
    localparam int BI = s % 8;
    assign seg_pix[s] =
      pix_q[5'(int'(com_nx) * slf_pkg::N_SEGEN + BY)][BI];
    assign seg_en[s]  = segen_q[BY][BI];
  end

  // ----------------------------------------------------------------
  // registered pin and drive outputs
  // ----------------------------------------------------------------
  logic [3:0]  com_d;
  logic [47:0] segd_d;
  logic        ph_d;
  logic [2:0]  shc_d;

  always_comb begin
    // type-b phase follows the frame, type-a the prescaler step
    ph_d   = wft_q ? odd_d : par_d;
    com_d  = 4'h0;
    segd_d = '0;
    // asleep or off, commons and segments sit at the minimum level
    if (state_d == slf_pkg::ST_RUN) begin
      com_d  = 4'(4'h1 << com_nx);
      segd_d = (seg_pix ^ {slf_pkg::N_SEG{ph_d}}) & seg_en;
    end
    shc_d  = slf_pkg::slf_mux_pins(mux_q);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_common_line          <= 4'h0;
      o_seg_drive            <= '0;
      o_drive_phase          <= 1'b0;
      o_frame_start          <= 1'b0;
      o_frame_irq            <= 1'b0;
      o_lcd_active           <= 1'b0;
      o_shared_pin_is_common <= 3'h0;
      o_shared_pin_oe        <= 3'h0;
      o_seg_pin_is_lcd       <= '0;
      o_seg_pin_oe           <= '0;
    end else begin
      o_common_line          <= com_d;
      o_seg_drive            <= segd_d;
      o_drive_phase          <= ph_d;
      o_frame_start          <= fstart_d;
      o_frame_irq            <= irq_d;
      o_lcd_active           <= (state_d == slf_pkg::ST_RUN);
      o_shared_pin_is_common <= shc_d;
      // common and segment drivers drive whatever the direction bit
      o_shared_pin_oe        <= shc_d | ~i_shared_pin_direction_bit;
      o_seg_pin_is_lcd       <= seg_en;
      o_seg_pin_oe           <= seg_en | ~i_seg_pin_direction_bit;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_bus_answer: assert property ((req && wait_q) |=> !o_avs_waitrequest)
    else $error("no answer one cycle after request");
  a_mux_reset: assert property ($rose(i_resetn) |->
    (mux_q == slf_pkg::MUX_STATIC && o_shared_pin_is_common == 3'h0))
    else $error("mux not static after reset");
  a_segen_reset: assert property ($rose(i_resetn) |->
    (o_seg_pin_is_lcd == '0)) else $error("segment on after reset");
  a_com_pins: assert property (1 |=>
    o_shared_pin_is_common == slf_pkg::slf_mux_pins($past(mux_q)))
    else $error("common pin takeover wrong");
  a_dir_override: assert property (1 |=> o_shared_pin_oe ==
    (slf_pkg::slf_mux_pins($past(mux_q)) |
     ~$past(i_shared_pin_direction_bit)))
    else $error("direction override wrong");
  a_no_irq_a: assert property (
    (!wft_q || mux_q == slf_pkg::MUX_STATIC) |=> !o_frame_irq)
    else $error("irq in type-a or static");
  a_irq_pair: assert property (o_frame_irq |-> (odd_q && wa_q))
    else $error("irq off the frame pair");
  a_pixel_write_error_flag_set: assert property ((commit && i_avs_write &&
    idx >= slf_pkg::IDX_PIX0 && idx < slf_pkg::IDX_PIXEND && !allowed)
    |=> pixel_write_error_flag_q) else $error("write error not flagged");
  a_pixel_write_error_flag_hold: assert property (pixel_write_error_flag_q &&
    !(commit && i_avs_write && idx == slf_pkg::IDX_CTRL) |=> pixel_write_error_flag_q)
    else $error("write error dropped");
  a_sys_sleep: assert property ((run && en_q && i_cpu_sleep &&
    src_q == slf_pkg::SRC_SYS) |=> !o_lcd_active)
    else $error("system source ran in sleep");
  a_osc_awake: assert property ((run && en_q && i_cpu_sleep &&
    !lcd_sleep_enable_q && src_q != slf_pkg::SRC_SYS) |=> o_lcd_active)
    else $error("oscillator source stopped in sleep");
  a_frame_common_line_0: assert property (o_frame_start &&
    o_lcd_active |-> o_common_line[0])
    else $error("frame not at common 0");
  a_sys_gap: assert property (sys_tick |=> (!sys_tick)[*8])
    else $error("system divider too fast");

  c_irq:   cover property (o_frame_irq);
  c_pixel_write_error_flag:  cover property ($rose(pixel_write_error_flag_q));
  c_sleep: cover property (state_q == slf_pkg::ST_SLEEP);
  c_quad:  cover property (o_common_line[3]);

endmodule : slf_frame_timing

`default_nettype wire
